//--- bsc_pkg.sv
// Shared constants and carriers for the bit-skip and call decode block.
// Assumes a 12-bit instruction word and an 11-bit program counter.
package bsc_pkg;
   localparam int INSN_W = 12;
   localparam int PC_W = 11;
   localparam int DATA_W = 8;
   localparam int RADDR_W = 5;
   localparam int BIDX_W = 3;
   localparam int OPC_W = 4;
   localparam int OPC_HI = 11;
   localparam int OPC_LO = 8;
   localparam int BIDX_HI = 7;
   localparam int BIDX_LO = 5;
   localparam int RADDR_HI = 4;
   localparam int RADDR_LO = 0;
   localparam int IMM_HI = 7;
   localparam int IMM_LO = 0;
   localparam int PAGE_HI = 10;
   localparam int PAGE_LO = 9;
   localparam int HALF_BIT = 8;
   localparam int STAT_PAGE_HI = 6;
   localparam int STAT_PAGE_LO = 5;
   localparam logic [OPC_W-1:0] OPC_BIT_TEST_SKIP_IF_SET = 4'h7;
   localparam logic [OPC_W-1:0] OPC_CALL = 4'h9;
   localparam logic [INSN_W-1:0] INSN_NOP = 12'h000;
   localparam logic [PC_W-1:0] PC_RESET = 11'h7ff;
   localparam logic [PC_W-1:0] PC_STEP = 11'h001;

   typedef struct packed {
      logic load;
      logic [PC_W-1:0] value;
   } bsc_pc_load_t;

   typedef struct packed {
      logic push;
      logic [PC_W-1:0] stack_top_entry;
   } bsc_push_t;
endpackage

//--- bsc_decode.sv
// Combinational decode of one instruction word into the two handled kinds.
// Assumes the word is stable for the whole cycle it is presented.
`timescale 1ns/1ns
module bsc_decode
   import bsc_pkg::*;
(
   // Instruction
   input wire logic [INSN_W-1:0] insn,
   // Decoded fields
   output logic is_skip,
   output logic is_call,
   output logic [BIDX_W-1:0] bit_index,
   output logic [RADDR_W-1:0] reg_addr,
   output logic [DATA_W-1:0] imm
);
   assign is_skip = insn[OPC_HI:OPC_LO] == OPC_BIT_TEST_SKIP_IF_SET;
   assign is_call = insn[OPC_HI:OPC_LO] == OPC_CALL;
   assign bit_index = insn[BIDX_HI:BIDX_LO];
   assign reg_addr = insn[RADDR_HI:RADDR_LO];
   assign imm = insn[IMM_HI:IMM_LO];
endmodule

//--- bsc_core.sv
// Executes the bit-test-skip-if-set and call instructions of the core.
// Assumes fetch presents one word per instruction cycle with its PC, and that
// the register file answers the fetched word's register field on reg_data
// in the same cycle. The counter and the stack act on pc_load and stack_push
// in the cycle they are seen; a stale reg_data makes the skip test misfire.
`timescale 1ns/1ns
module bsc_core
   import bsc_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Fetch
   input wire logic [INSN_W-1:0] insn,
   input wire logic [PC_W-1:0] insn_pc,
   // Register file and status
   input wire logic [DATA_W-1:0] reg_data,
   input wire logic [DATA_W-1:0] status,
   output logic [RADDR_W-1:0] reg_addr,
   // Program counter and stack
   output bsc_pc_load_t pc_load,
   output bsc_push_t stack_push,
   // Pipeline
   output logic flush,
   output logic [INSN_W-1:0] exec_insn,
   output logic status_we
);
   typedef enum logic [1:0] {
      ST_EXEC = 2'b01,
      ST_NOP = 2'b10
   } bsc_state_t;

   bsc_state_t state;
   bsc_state_t next_state;
   logic is_skip;
   logic is_call;
   logic [BIDX_W-1:0] bit_index;
   logic [RADDR_W-1:0] dec_addr;
   logic [DATA_W-1:0] imm;
   logic active;
   logic skip_taken;
   logic call_taken;
   logic tested_bit;
   logic [DATA_W-1:0] bit_hit;
   logic [PC_W-1:0] call_target;
   logic load_pulse;
   logic [PC_W-1:0] load_value;
   logic push_pulse;
   logic [PC_W-1:0] push_value;

   bsc_decode bsc_decode_i (
      .insn(insn),
      .is_skip(is_skip),
      .is_call(is_call),
      .bit_index(bit_index),
      .reg_addr(dec_addr),
      .imm(imm)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Functions
   // Call target: page from status, bit 8 forced low, offset from the word
   function automatic logic [PC_W-1:0] call_dest(input logic [DATA_W-1:0] stat,
                                                 input logic [DATA_W-1:0] offset);
      call_dest = {stat[STAT_PAGE_HI:STAT_PAGE_LO],
                   1'b0,
                   offset};
   endfunction

   // Return address wraps at the top of program memory, as the counter does
   function automatic logic [PC_W-1:0] return_addr(input logic [PC_W-1:0] pc);
      return_addr = pc + PC_STEP;
   endfunction

   // Both a taken skip and a call turn the following fetch slot into a NOP
   function automatic logic discards_next(input logic skip_hit,
                                          input logic call_hit);
      discards_next = skip_hit || call_hit;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Bit select
   // One lane per data bit, so the tested bit needs no variable index
   for (genvar lane = 0; lane < DATA_W; lane = lane + 1) begin : g_bit_lane
      assign bit_hit[lane] = reg_data[lane] && (bit_index == BIDX_W'(lane));
   end
   assign tested_bit = |bit_hit;

   ////////////////////////////////////////////////////////////////////////////
   // Decode terms
   // A word fetched while the pipe is flushed is thrown away, not executed
   // A call in the NOP slot is dropped with that slot
   assign active = state == ST_EXEC;
   assign skip_taken = active && is_skip && tested_bit;
   assign call_taken = active && is_call;
   assign call_target = call_dest(status, imm);

   always_comb begin
      next_state = ST_EXEC;
      case (state)
         ST_EXEC: begin
            if (discards_next(skip_taken, call_taken)) begin
               next_state = ST_NOP;
            end else begin
               next_state = ST_EXEC;
            end
         end
         ST_NOP: begin
            next_state = ST_EXEC;
         end
         default: begin
            next_state = ST_EXEC;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // State
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state <= ST_EXEC;
      end else begin
         state <= next_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register read address, registered to keep outputs flop-driven
   // Informational only; the skip test reads reg_data for the word in fetch
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         reg_addr <= '0;
      end else begin
         reg_addr <= dec_addr;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Program counter load pulse
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         load_pulse <= 1'b0;
      end else begin
         load_pulse <= call_taken;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Program counter load value; free running, only valid with the pulse
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         load_value <= '0;
      end else begin
         load_value <= call_target;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Stack push pulse
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         push_pulse <= 1'b0;
      end else begin
         push_pulse <= call_taken;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Stack entry; the return address is the word after the call
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         push_value <= '0;
      end else begin
         push_value <= return_addr(insn_pc);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output carriers
   // Plain wiring of flops, so every output still comes from a register
   assign pc_load = {load_pulse, load_value};
   assign stack_push = {push_pulse, push_value};

   ////////////////////////////////////////////////////////////////////////////
   // Pipeline flush
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         flush <= 1'b0;
      end else begin
         flush <= discards_next(skip_taken, call_taken);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Executed word
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         exec_insn <= INSN_NOP;
      end else begin
         exec_insn <= active ? insn : INSN_NOP;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Status write: never asserted by these two instructions
   // Tied low on purpose; a flag write here would corrupt the page bits
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         status_we <= 1'b0;
      end else begin
         status_we <= 1'b0;
      end
   end
endmodule

//--- bsc_core_assertions.sv
// Checker for the bit-skip and call block, sees only its ports.
// Assumes reg_data answers the fetched word in the same cycle.
`timescale 1ns/1ns
module bsc_core_chk
   import bsc_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [INSN_W-1:0] insn,
   input wire logic [PC_W-1:0] insn_pc,
   input wire logic [DATA_W-1:0] reg_data,
   input wire logic [DATA_W-1:0] status,
   input wire logic [RADDR_W-1:0] reg_addr,
   input wire bsc_pc_load_t pc_load,
   input wire bsc_push_t stack_push,
   input wire logic flush,
   input wire logic [INSN_W-1:0] exec_insn,
   input wire logic status_we
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   logic call, skp, bit_on;
   // A word seen while flush is high sits in the NOP slot
   assign call = insn[OPC_HI:OPC_LO] == OPC_CALL && !flush;
   assign skp = insn[OPC_HI:OPC_LO] == OPC_BIT_TEST_SKIP_IF_SET && !flush;
   assign bit_on = reg_data[insn[BIDX_HI:BIDX_LO]];
   a_skip_discard: assert property (skp && bit_on |=> flush ##1 exec_insn == INSN_NOP)
      else $error("skip set did not discard next word");
   a_skip_keep: assert property (skp && !bit_on |=> !flush)
      else $error("skip clear discarded next word");
   a_call_push: assert property (call |=> stack_push.push &&
      stack_push.stack_top_entry == $past(insn_pc) + PC_STEP) else $error("bad return push");
   a_call_low: assert property (call |=> pc_load.load &&
      pc_load.value[IMM_HI:IMM_LO] == $past(insn[IMM_HI:IMM_LO])) else $error("bad target low");
   a_call_page: assert property (call |=> pc_load.value[PAGE_HI:PAGE_LO] ==
      $past(status[STAT_PAGE_HI:STAT_PAGE_LO])) else $error("bad target page");
   a_call_half: assert property (call |=> !pc_load.value[HALF_BIT])
      else $error("target bit 8 set");
   a_call_two: assert property (call |=> flush ##1 !pc_load.load && !stack_push.push)
      else $error("call not two cycles");
   a_no_status: assert property (!status_we)
      else $error("status written");
   a_slot_refused: assert property (flush |=> !flush && !pc_load.load &&
      !stack_push.push && exec_insn == INSN_NOP) else $error("discarded word acted");
   a_exec_pass: assert property (!flush |=> exec_insn == $past(insn))
      else $error("live word not executed");
   a_addr_copy: assert property (reg_addr == $past(insn[RADDR_HI:RADDR_LO]))
      else $error("register address not copied");
   c_call: cover property (call ##2 call);
   c_refused: cover property (flush && insn[OPC_HI:OPC_LO] == OPC_CALL);
   c_skip: cover property (skp && bit_on);
   c_page: cover property (call && status[STAT_PAGE_HI:STAT_PAGE_LO] == 2'h3);
endmodule
bind bsc_core bsc_core_chk bsc_core_chk_i (.clk, .sys_rst, .insn, .insn_pc, .reg_data,
   .status, .reg_addr, .pc_load, .stack_push, .flush, .exec_insn, .status_we);

//--- tb_top.sv
// Random-word bench for the bit-skip and call block.
// Drives every input itself; a second process scores the outputs.
`timescale 1ns/1ns
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin err_count++; \
   $display("wrong value %s exp %h got %h", n, e, g); end end
module tb_top
   import bsc_pkg::*;
();
   typedef struct packed {
      bsc_pc_load_t l;
      bsc_push_t p;
      logic f;
      logic [INSN_W-1:0] x;
      logic [RADDR_W-1:0] a;
   } bsc_exp_t;
   logic clk = 0, sys_rst = 1, slot = 0, pv = 0, flush, status_we;
   logic [INSN_W-1:0] insn = 0, exec_insn, wd;
   logic [PC_W-1:0] insn_pc = 0;
   logic [DATA_W-1:0] reg_data = 0, status = 0;
   logic [RADDR_W-1:0] reg_addr;
   logic [31:0] r, r2;
   bsc_pc_load_t pc_load;
   bsc_push_t stack_push;
   bsc_exp_t q[$], e, pend;
   int err_count = 0, comparisons = 0, seed = 32'h86d5;
   bsc_core bsc_core_i (.clk, .sys_rst, .insn, .insn_pc, .reg_data, .status, .reg_addr,
      .pc_load, .stack_push, .flush, .exec_insn, .status_we);
   initial forever #20 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////
   always @(negedge clk) if (q.size() > 0) begin
      e = q.pop_front();
      `CHK("exec", e.x, exec_insn)
      `CHK("flush", e.f, flush)
      `CHK("load", e.l.load, pc_load.load)
      `CHK("push", e.p.push, stack_push.push)
      if (e.l.load) begin
         `CHK("target", e.l.value, pc_load.value)
         `CHK("entry", e.p.stack_top_entry, stack_push.stack_top_entry)
      end
      `CHK("swe", 1'b0, status_we)
      `CHK("addr", e.a, reg_addr)
   end
   task automatic results;
      if (err_count == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Expectation of a word is queued one edge later, when its answer is due
   initial begin
      repeat (4) @(posedge clk);
      sys_rst <= 0;
      repeat (400) begin
         @(posedge clk);
         if (pv) q.push_back(pend);
         r = $random(seed);
         r2 = $random(seed);
         wd = r[11:0];
         if (r[13]) wd[11:8] = r[12] ? OPC_CALL : OPC_BIT_TEST_SKIP_IF_SET;
         if (r[15:14] == 0) wd[7:0] = 8'hff;
         insn <= wd;
         insn_pc <= r2[10:0];
         reg_data <= r2[18:11];
         status <= r2[26:19];
         pend = '0;
         pend.a = wd[RADDR_HI:RADDR_LO];
         pv = 1;
         if (!slot) begin
            pend.x = wd;
            if (wd[11:8] == OPC_CALL) begin
               pend.l = {1'b1, r2[25:24], 1'b0, wd[7:0]};
               pend.p = {1'b1, r2[10:0] + PC_STEP};
               pend.f = 1;
            end else if (wd[11:8] == OPC_BIT_TEST_SKIP_IF_SET && r2[11 + wd[7:5]]) pend.f = 1;
         end
         slot = pend.f;
      end
      @(posedge clk);
      q.push_back(pend);
      insn <= INSN_NOP;
      repeat (3) @(posedge clk);
      if (q.size() > 0) err_count++;
      results;
   end
endmodule
